// ===== rtl/sdwb_top.sv
// write burst control: apb config, link-clock command queue and beat capture
// Summary of operation
// R01 - bursts are fixed eight, fixed chopped four, or chosen per command
// R02 - with per-command choice, A12 low gives chopped four, high gives eight
// R03 - A10 low: plain write, bank stays open afterwards
// R04 - A10 high: write then automatic close of the bank
// R05 - byte mask exists on x8/x16 only, shares pin with inversion/strobe
// R06 - mask acts on writes only, never together with bus inversion
// R07 - mask low on a lane discards that lane's data
// R08 - mask high on a lane stores that lane's data
// R09 - with crc on, mask enable picks persistent, else non-persistent mode
// R10 - write latency is additive plus column latency, e.g. 10+9=19
// R11 - eight beats from fixed setting 00, or 01 with A12 high
// R12 - two-clock preamble forbids column latency 9
// R13 - two-clock preamble forbids commands five clocks apart
// R14 - one-clock preamble allows five-clock spacing with a data gap
// R15 - recovery and write-to-read count from edge after last beat
// R16 - field value 10 fixes chopped four regardless of A12
// R17 - controller waits recovery time before precharging the bank
// R18 - beats captured on consecutive clocks from latency point, only burst length
`timescale 1ns/1ps
`default_nettype none
module sdwb_top #(
  parameter int DQ_W = 16,
  parameter int QDEPTH = 16,
  parameter int CNT_W = 8
) (
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // link side, device clock from the controller
  input wire logic LINK_CLK,
  input wire logic CMD_WRITE,
  input wire logic CMD_A10,
  input wire logic CMD_A12,
  input wire logic [sdwb_pkg::BANK_W-1:0] CMD_BANK,
  input wire logic [sdwb_pkg::COL_W-1:0] CMD_COL,
  input wire logic [2*DQ_W-1:0] WR_DATA,
  input wire logic [2*((DQ_W+7)/8)-1:0] WRITE_BYTE_MASK,
  // array write port and bank events, link clock
  output logic ARRAY_WE,
  output logic [sdwb_pkg::BANK_W-1:0] ARRAY_BANK,
  output logic [sdwb_pkg::COL_W-1:0] ARRAY_COL,
  output logic [2*DQ_W-1:0] ARRAY_DATA,
  output logic [2*((DQ_W+7)/8)-1:0] ARRAY_BYTE_EN,
  output logic RECOVERY_REF,
  output logic AUTO_PRECHARGE,
  output logic [sdwb_pkg::BANK_W-1:0] PRECHARGE_BANK,
  output logic CRC_PERSISTENT
);
  localparam int NB = 2*((DQ_W+7)/8);
  localparam int PW = $clog2(QDEPTH);
  localparam int CW = $clog2(QDEPTH+1);

  // ---------------- core domain ----------------
  sdwb_pkg::sdwb_cfg_t cfg_q;
  logic req_tgl_q;
  logic ack_s1_q, ack_s2_q, ack_tgl_q;
  logic [6:0] err_s1_q, err_s2_q, lstat;
  logic [CNT_W-1:0] gray_s1_q, gray_s2_q, gray_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic busy, setup, access, is_cfg, cfg_wr;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [CNT_W-1:0] count_bin;

  assign busy = req_tgl_q != ack_s2_q;
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign is_cfg = (PADDR == sdwb_pkg::ADDR_CTRL) || (PADDR == sdwb_pkg::ADDR_LAT);
  // config writes stall while the previous one is still crossing
  assign PREADY = !(PWRITE && is_cfg && busy);
  assign cfg_wr = access && PWRITE && is_cfg && !busy;

  always_comb begin
    count_bin = '0;
    for (int i = CNT_W-1; i >= 0; i--) begin
      if (i == CNT_W-1) begin
        count_bin[i] = gray_s2_q[i];
      end else begin
        count_bin[i] = count_bin[i+1] ^ gray_s2_q[i];
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    rd_ok = 1'b1;
    case (PADDR)
      sdwb_pkg::ADDR_CTRL: begin
        rd_mux[sdwb_pkg::CTRL_BM_LSB +: 2] = cfg_q.bm;
        rd_mux[sdwb_pkg::CTRL_PRE2] = cfg_q.pre2;
        rd_mux[sdwb_pkg::CTRL_MASK] = cfg_q.mask_en;
        rd_mux[sdwb_pkg::CTRL_DBI] = cfg_q.dbi_en;
        rd_mux[sdwb_pkg::CTRL_CRC] = cfg_q.crc_en;
      end
      sdwb_pkg::ADDR_LAT: begin
        rd_mux[sdwb_pkg::LAT_AL_LSB +: sdwb_pkg::LAT_W] = cfg_q.al;
        rd_mux[sdwb_pkg::LAT_CWL_LSB +: sdwb_pkg::LAT_W] = cfg_q.write_column_latency;
      end
      sdwb_pkg::ADDR_STATUS: begin
        rd_mux[sdwb_pkg::ST_OVF:sdwb_pkg::ST_CRCP] = err_s2_q[6:1];
        rd_mux[sdwb_pkg::ST_BUSY] = busy;
      end
      sdwb_pkg::ADDR_COUNT: begin
        rd_mux[CNT_W-1:0] = count_bin;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // read data and error answer prepared in the setup cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= PWRITE ? '0 : rd_mux;
      pslverr_q <= !rd_ok || (PWRITE && !is_cfg);
    end
  end
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;

  // config registers, each accepted write sent across by toggle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_q <= sdwb_pkg::CFG_RST;
      req_tgl_q <= 1'b0;
    end else if (cfg_wr) begin
      req_tgl_q <= !req_tgl_q;
      if (PADDR == sdwb_pkg::ADDR_CTRL) begin
        cfg_q.bm <= PWDATA[sdwb_pkg::CTRL_BM_LSB +: 2];
        cfg_q.pre2 <= PWDATA[sdwb_pkg::CTRL_PRE2];
        cfg_q.mask_en <= PWDATA[sdwb_pkg::CTRL_MASK];
        cfg_q.dbi_en <= PWDATA[sdwb_pkg::CTRL_DBI];
        cfg_q.crc_en <= PWDATA[sdwb_pkg::CTRL_CRC];
      end else begin
        cfg_q.al <= PWDATA[sdwb_pkg::LAT_AL_LSB +: sdwb_pkg::LAT_W];
        cfg_q.write_column_latency <= PWDATA[sdwb_pkg::LAT_CWL_LSB +: sdwb_pkg::LAT_W];
      end
    end
  end

  // link state into core: ack toggle, status levels, gray count
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      err_s1_q <= '0;
      err_s2_q <= '0;
      gray_s1_q <= '0;
      gray_s2_q <= '0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      err_s1_q <= lstat;
      err_s2_q <= err_s1_q;
      gray_s1_q <= gray_q;
      gray_s2_q <= gray_s1_q;
    end
  end

  // ---------------- link domain ----------------
  logic lrst_s1_q, link_rst;
  logic req_s1_q, req_s2_q;
  sdwb_pkg::sdwb_cfg_t lcfg_q;
  logic [sdwb_pkg::TIME_W-1:0] time_q, wl;
  sdwb_pkg::sdwb_ent_t queue_q [QDEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] count_q;
  sdwb_pkg::sdwb_cmd_t cur_q, cmd_now, push_cmd, last_push_q;
  logic active_q;
  logic [2:0] idx_q, idx_now, len_now;
  logic hit, push, full, cap, store, last;
  logic mask_act;
  logic [3:0] since_q;
  logic err_space_q, err_cwl_q, err_ovf_q;
  logic [CNT_W-1:0] bursts_q;

  // reset brought into the link clock
  always_ff @(posedge LINK_CLK) begin
    lrst_s1_q <= RST;
    link_rst <= lrst_s1_q;
  end

  // config taken when the request toggle has settled
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      lcfg_q <= sdwb_pkg::CFG_RST;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != ack_tgl_q) begin
        lcfg_q <= cfg_q;
        ack_tgl_q <= req_s2_q;
      end
    end
  end

  // mask needs x8/x16 and inversion off; it only touches write data
  assign mask_act = lcfg_q.mask_en && !lcfg_q.dbi_en && (DQ_W != 4); // see R05 see R06
  assign wl = sdwb_pkg::TIME_W'(lcfg_q.al) + sdwb_pkg::TIME_W'(lcfg_q.write_column_latency); // see R10

  always_comb begin
    push_cmd.autoclose = CMD_A10; // see R03 see R04
    push_cmd.bank = CMD_BANK;
    push_cmd.col = CMD_COL;
    case (lcfg_q.bm)
      sdwb_pkg::BM_BL8: begin
        push_cmd.bl8 = 1'b1; // see R11
      end
      sdwb_pkg::BM_OTF: begin
        push_cmd.bl8 = CMD_A12; // see R02 see R11
      end
      sdwb_pkg::BM_BC4: begin
        push_cmd.bl8 = 1'b0; // see R16
      end
      default: begin
        push_cmd.bl8 = 1'b1;
      end
    endcase
  end

  assign full = count_q == CW'(QDEPTH);
  assign push = CMD_WRITE && !full;
  assign hit = (count_q != '0) && (time_q == queue_q[rd_ptr_q].due);

  // pending writes wait in order for their latency point
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      time_q <= '0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      last_push_q <= '0;
    end else begin
      time_q <= time_q + 1'b1;
      if (push) begin
        queue_q[wr_ptr_q] <= '{due: time_q + wl, cmd: push_cmd}; // see R10
        wr_ptr_q <= PW'((32'(wr_ptr_q) + 1) % QDEPTH);
        last_push_q <= push_cmd;
      end
      if (hit) begin
        rd_ptr_q <= PW'((32'(rd_ptr_q) + 1) % QDEPTH);
      end
      count_q <= count_q + CW'(push) - CW'(hit);
    end
  end

  // burst slot: four link clocks, two beats each
  assign cap = hit || active_q;
  assign idx_now = hit ? 3'h0 : idx_q;
  assign cmd_now = hit ? queue_q[rd_ptr_q].cmd : cur_q;
  assign len_now = cmd_now.bl8 ? sdwb_pkg::BL8_CLKS : sdwb_pkg::BC4_CLKS; // see R01
  assign store = cap && (idx_now < len_now); // see R18
  assign last = cap && (idx_now == len_now - 3'h1);

  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      active_q <= 1'b0;
      idx_q <= '0;
      cur_q <= '0;
    end else if (hit) begin
      cur_q <= queue_q[rd_ptr_q].cmd;
      active_q <= 1'b1;
      idx_q <= 3'h1; // see R18
    end else if (active_q) begin
      idx_q <= idx_q + 3'h1;
      active_q <= idx_q != sdwb_pkg::SLOT_CLKS - 3'h1;
    end
  end

  // array write port; masked lanes keep their stored bytes
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      ARRAY_WE <= 1'b0;
      ARRAY_BANK <= '0;
      ARRAY_COL <= '0;
      ARRAY_DATA <= '0;
      ARRAY_BYTE_EN <= '0;
    end else begin
      ARRAY_WE <= store;
      ARRAY_BANK <= cmd_now.bank;
      ARRAY_COL <= cmd_now.col + sdwb_pkg::COL_W'({idx_now, 1'b0});
      ARRAY_DATA <= WR_DATA;
      ARRAY_BYTE_EN <= mask_act ? WRITE_BYTE_MASK : {NB{1'b1}}; // see R07 see R08
    end
  end

  // edge after the last beat: recovery reference and optional close
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      RECOVERY_REF <= 1'b0;
      AUTO_PRECHARGE <= 1'b0;
      PRECHARGE_BANK <= '0;
      CRC_PERSISTENT <= 1'b0;
      bursts_q <= '0;
      gray_q <= '0;
    end else begin
      RECOVERY_REF <= last; // see R15
      AUTO_PRECHARGE <= last && cmd_now.autoclose; // see R04 see R03
      PRECHARGE_BANK <= cmd_now.bank;
      CRC_PERSISTENT <= lcfg_q.crc_en && lcfg_q.mask_en; // see R09
      if (last) begin
        bursts_q <= bursts_q + 1'b1;
        gray_q <= (bursts_q + 1'b1) ^ ((bursts_q + 1'b1) >> 1);
      end
    end
  end

  // command spacing and latency checks, sticky until reset
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      since_q <= sdwb_pkg::SPACE_MAX;
      err_space_q <= 1'b0;
      err_cwl_q <= 1'b0;
      err_ovf_q <= 1'b0;
    end else begin
      if (CMD_WRITE) begin
        since_q <= 4'h1;
      end else if (since_q != sdwb_pkg::SPACE_MAX) begin
        since_q <= since_q + 4'h1;
      end
      if (CMD_WRITE && lcfg_q.pre2 && since_q == sdwb_pkg::SPACE_FORBID_2T) begin
        err_space_q <= 1'b1; // see R13
      end
      if (hit && active_q) begin
        err_space_q <= 1'b1; // see R14
      end
      if (CMD_WRITE && lcfg_q.pre2 && lcfg_q.write_column_latency == sdwb_pkg::CWL_FORBID_2T) begin
        err_cwl_q <= 1'b1; // see R12
      end
      if (CMD_WRITE && full) begin
        err_ovf_q <= 1'b1;
      end
    end
  end

  always_comb begin
    lstat = '0;
    lstat[sdwb_pkg::ST_CRCP] = CRC_PERSISTENT;
    lstat[sdwb_pkg::ST_MASK] = mask_act;
    lstat[sdwb_pkg::ST_CONFL] = lcfg_q.mask_en && lcfg_q.dbi_en;
    lstat[sdwb_pkg::ST_SPACE] = err_space_q;
    lstat[sdwb_pkg::ST_CWL] = err_cwl_q;
    lstat[sdwb_pkg::ST_OVF] = err_ovf_q;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (link_rst);

  a_bl8_four_clocks: assert property (hit && queue_q[rd_ptr_q].cmd.bl8 |=> ARRAY_WE [*4]) // see R01
    else $error("eight-beat burst not stored over four clocks");
  a_bc4_two_clocks: assert property (hit && !queue_q[rd_ptr_q].cmd.bl8 |=>
    ARRAY_WE [*2] ##1 !ARRAY_WE) // see R18
    else $error("chopped burst stored wrong number of clocks");
  a_otf_a12_select: assert property (CMD_WRITE && !full && lcfg_q.bm == sdwb_pkg::BM_OTF
    |=> last_push_q.bl8 == $past(CMD_A12)) // see R02
    else $error("per-command length not taken from A12");
  a_fixed_len_select: assert property (CMD_WRITE && !full && lcfg_q.bm != sdwb_pkg::BM_OTF
    |=> last_push_q.bl8 == ($past(lcfg_q.bm) != sdwb_pkg::BM_BC4)) // see R11 see R16
    else $error("fixed length setting not honoured");
  a_wl_nine: assert property (CMD_WRITE && count_q == '0 && !active_q
    && wl == sdwb_pkg::TIME_W'(sdwb_pkg::WL_EX_A) |-> ##9 hit) // see R10
    else $error("first beat not nine clocks after command");
  a_wl_nineteen: assert property (CMD_WRITE && count_q == '0 && !active_q
    && wl == sdwb_pkg::TIME_W'(sdwb_pkg::WL_EX_B) |-> ##19 hit) // see R10
    else $error("first beat not nineteen clocks after command");
  a_mask_lane_pass: assert property (store && mask_act |=>
    ARRAY_BYTE_EN == $past(WRITE_BYTE_MASK)) // see R07 see R08
    else $error("lane enables do not follow the byte mask");
  a_dbi_no_mask: assert property (ARRAY_WE && $past(lcfg_q.dbi_en) |-> &ARRAY_BYTE_EN) // see R06
    else $error("mask applied while inversion enabled");
  a_recov_after_bl8: assert property (hit && queue_q[rd_ptr_q].cmd.bl8 |-> ##4 RECOVERY_REF) // see R15
    else $error("recovery reference not after last eight-beat clock");
  a_recov_after_bc4: assert property (hit && !queue_q[rd_ptr_q].cmd.bl8 |-> ##2 RECOVERY_REF) // see R15
    else $error("recovery reference not after last chopped clock");
  a_autoclose_bank: assert property (AUTO_PRECHARGE |-> RECOVERY_REF && $past(cmd_now.autoclose)) // see R04
    else $error("bank closed without autoclose write");
  a_plain_stays_open: assert property (last && !cmd_now.autoclose |=> !AUTO_PRECHARGE) // see R03
    else $error("plain write closed the bank");
  a_crc_mode_pick: assert property (lcfg_q.crc_en && !lcfg_q.mask_en |=> !CRC_PERSISTENT) // see R09
    else $error("persistent crc without mask enable");
  c_bl8_burst: cover property (hit && queue_q[rd_ptr_q].cmd.bl8 ##4 RECOVERY_REF);
  c_bc4_burst: cover property (hit && !queue_q[rd_ptr_q].cmd.bl8 ##2 RECOVERY_REF);
  c_autoclose: cover property (AUTO_PRECHARGE);
  c_masked_lane: cover property (store && mask_act && !(&WRITE_BYTE_MASK));
endmodule
`default_nettype wire

// ===== rtl/sdwb_pkg.sv
// constants and carrier types for the sdram write burst block
package sdwb_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LAT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  // control field positions
  localparam int CTRL_BM_LSB = 0;
  localparam int CTRL_PRE2 = 2;
  localparam int CTRL_MASK = 3;
  localparam int CTRL_DBI = 4;
  localparam int CTRL_CRC = 5;
  localparam int LAT_W = 6;
  localparam int LAT_AL_LSB = 0;
  localparam int LAT_CWL_LSB = 8;
  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_CRCP = 1;
  localparam int ST_MASK = 2;
  localparam int ST_CONFL = 3;
  localparam int ST_SPACE = 4;
  localparam int ST_CWL = 5;
  localparam int ST_OVF = 6;
  // burst-length field codes
  localparam logic [1:0] BM_BL8 = 2'h0;
  localparam logic [1:0] BM_OTF = 2'h1;
  localparam logic [1:0] BM_BC4 = 2'h2;
  // link clocks per burst slot and per stored length (two beats a clock)
  localparam logic [2:0] SLOT_CLKS = 3'h4;
  localparam logic [2:0] BL8_CLKS = 3'h4;
  localparam logic [2:0] BC4_CLKS = 3'h2;
  // two-clock preamble limits
  localparam logic [5:0] CWL_FORBID_2T = 6'h09;
  localparam logic [3:0] SPACE_FORBID_2T = 4'h5;
  localparam logic [3:0] SPACE_MAX = 4'hF;
  // latency examples checked by assertions
  localparam int WL_EX_A = 9;
  localparam int WL_EX_B = 19;
  localparam int BANK_W = 4;
  localparam int COL_W = 10;
  localparam int TIME_W = 8;

  typedef struct packed {
    logic [1:0] bm;
    logic pre2;
    logic mask_en;
    logic dbi_en;
    logic crc_en;
    logic [LAT_W-1:0] al;
    logic [LAT_W-1:0] write_column_latency;
  } sdwb_cfg_t;

  // reset configuration: fixed eight, additive 0, column latency 9
  localparam sdwb_cfg_t CFG_RST = '{bm: BM_BL8, pre2: 1'b0, mask_en: 1'b0, dbi_en: 1'b0,
    crc_en: 1'b0, al: 6'h00, write_column_latency: 6'h09};

  typedef struct packed {
    logic bl8;
    logic autoclose;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
  } sdwb_cmd_t;

  typedef struct packed {
    logic [TIME_W-1:0] due;
    sdwb_cmd_t cmd;
  } sdwb_ent_t;
endpackage

// ===== tb/sdwb_ctrl_model.sv
// controller-side model: write commands, beat pattern and lane mask
`timescale 1ns/1ps
`default_nettype none
module sdwb_ctrl_model (
  // link clock
  input wire logic link_clk,
  // command toward the device
  output logic cmd_write,
  output logic cmd_a10,
  output logic cmd_a12,
  output logic [sdwb_pkg::BANK_W-1:0] cmd_bank,
  output logic [sdwb_pkg::COL_W-1:0] cmd_col,
  // beats, lane mask and clock index
  output logic [31:0] wr_data,
  output logic [3:0] wr_mask,
  output logic [15:0] lcyc
);
  initial begin
    lcyc = 16'h0000;
    cmd_write = 1'b0;
    cmd_a10 = 1'b0;
    cmd_a12 = 1'b0;
    cmd_bank = 4'h0;
    cmd_col = 10'h000;
    wr_mask = 4'hF;
  end
  always @(posedge link_clk) begin
    lcyc <= lcyc + 16'h0001;
  end
  // beats change every clock so a sample one clock off shows
  assign wr_data = {lcyc ^ 16'h5A3C, lcyc};
  // write commands only; no precharge is sent, so no recovery wait is owed
  task automatic issue(input logic a12, input logic a10, input logic [3:0] bank,
    input logic [9:0] col, input logic [3:0] mask, output logic [15:0] t);
    @(posedge link_clk);
    cmd_write <= 1'b1;
    cmd_a12 <= a12;
    cmd_a10 <= a10;
    cmd_bank <= bank;
    cmd_col <= col;
    wr_mask <= mask;
    @(negedge link_clk);
    t = lcyc;
    @(posedge link_clk);
    cmd_write <= 1'b0;
    cmd_bank <= ~bank;
    cmd_col <= ~col;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_sdwb_write_burst_control.sv
// self-checking bench for the write burst control block
`timescale 1ns/1ps
`default_nettype none
module test_sdwb_write_burst_control;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [5:0] al;
    logic [5:0] write_column_latency;
    logic a12;
    logic a10;
    logic [3:0] mask;
    logic [2:0] n;
    logic [3:0] be;
    logic crcp;
  } sdwb_row_t;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, cmd_write, cmd_a10, cmd_a12, arr_we, rec_ref, auto_pre, crc_p, er;
  logic [3:0] cmd_bank, arr_bank, pre_bank, wr_mask, arr_be;
  logic [9:0] cmd_col, arr_col;
  logic [31:0] prdata, wr_data, arr_data, rd;
  logic [15:0] lcyc, t0, t1;
  logic [15:0] we_t[$];
  logic [31:0] we_d[$];
  logic [13:0] we_c[$];
  logic [3:0] we_be[$];
  logic [15:0] rf_t[$];
  logic [4:0] rf_a[$];
  int bad_count = 0;
  int cmp_count = 0;
  int bursts = 0;
  sdwb_row_t rows[9] = '{
    '{8'h00, 6'h00, 6'h09, 1'h0, 1'h0, 4'hF, 3'h4, 4'hF, 1'h0},
    '{8'h01, 6'h00, 6'h09, 1'h1, 1'h1, 4'hF, 3'h4, 4'hF, 1'h0},
    '{8'h01, 6'h00, 6'h09, 1'h0, 1'h0, 4'hF, 3'h2, 4'hF, 1'h0},
    '{8'h02, 6'h00, 6'h09, 1'h1, 1'h0, 4'hF, 3'h2, 4'hF, 1'h0},
    '{8'h03, 6'h00, 6'h09, 1'h0, 1'h1, 4'hF, 3'h4, 4'hF, 1'h0},
    '{8'h08, 6'h00, 6'h09, 1'h1, 1'h0, 4'h5, 3'h4, 4'h5, 1'h0},
    '{8'h18, 6'h00, 6'h09, 1'h1, 1'h0, 4'h5, 3'h4, 4'hF, 1'h0},
    '{8'h28, 6'h0A, 6'h09, 1'h1, 1'h1, 4'hA, 3'h4, 4'hA, 1'h1},
    '{8'h20, 6'h00, 6'h09, 1'h0, 1'h0, 4'h6, 3'h4, 4'hF, 1'h0}};
  always #5 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;
  sdwb_top sdwb_top_inst (.CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK_CLK(link_clk), .CMD_WRITE(cmd_write), .CMD_A10(cmd_a10),
    .CMD_A12(cmd_a12), .CMD_BANK(cmd_bank), .CMD_COL(cmd_col), .WR_DATA(wr_data),
    .WRITE_BYTE_MASK(wr_mask), .ARRAY_WE(arr_we), .ARRAY_BANK(arr_bank), .ARRAY_COL(arr_col),
    .ARRAY_DATA(arr_data), .ARRAY_BYTE_EN(arr_be), .RECOVERY_REF(rec_ref),
    .AUTO_PRECHARGE(auto_pre), .PRECHARGE_BANK(pre_bank), .CRC_PERSISTENT(crc_p));
  sdwb_ctrl_model sdwb_ctrl_model_inst (.link_clk(link_clk), .cmd_write(cmd_write),
    .cmd_a10(cmd_a10), .cmd_a12(cmd_a12), .cmd_bank(cmd_bank), .cmd_col(cmd_col),
    .wr_data(wr_data), .wr_mask(wr_mask), .lcyc(lcyc));
  // collect array writes and recovery points mid-cycle
  always @(negedge link_clk) begin
    if (arr_we === 1'b1) begin
      we_t.push_back(lcyc);
      we_d.push_back(arr_data);
      we_c.push_back({arr_bank, arr_col});
      we_be.push_back(arr_be);
    end
    if (rec_ref === 1'b1) begin
      rf_t.push_back(lcyc);
      rf_a.push_back({auto_pre, pre_bank});
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] c, input logic [5:0] al, input logic [5:0] write_column_latency);
    apb(1'b1, sdwb_pkg::ADDR_CTRL, {24'h0, c});
    apb(1'b1, sdwb_pkg::ADDR_LAT, {18'h0, write_column_latency, 2'h0, al});
    repeat (8) @(posedge link_clk);
  endtask
  task automatic chk_burst(input logic [15:0] t, input int wl, input int n, input logic [3:0] bank,
    input logic [9:0] col, input logic [3:0] be, input logic a10);
    logic [15:0] k;
    logic [4:0] a;
    bursts++;
    for (int i = 0; i < n; i++) begin
      k = t + 16'(wl + i);
      chk(we_t.pop_front(), k + 16'h0001);
      chk(we_d.pop_front(), {k ^ 16'h5A3C, k});
      chk(we_c.pop_front(), {bank, col + 10'(2 * i)});
      chk(we_be.pop_front(), be);
    end
    chk(rf_t.pop_front(), t + 16'(wl + n));
    a = rf_a.pop_front();
    chk(a[4], a10);
    if (a10) chk(a[3:0], bank);
  endtask
  task automatic pair(input int s, input int wl);
    sdwb_ctrl_model_inst.issue(1'b1, 1'b0, 4'h3, 10'h040, 4'hF, t0);
    repeat (s - 2) @(posedge link_clk);
    sdwb_ctrl_model_inst.issue(1'b0, 1'b1, 4'h6, 10'h100, 4'hF, t1);
    repeat (wl + 10) @(posedge link_clk);
    chk_burst(t0, wl, 4, 4'h3, 10'h040, 4'hF, 1'b0);
    chk_burst(t1, wl, 4, 4'h6, 10'h100, 4'hF, 1'b1);
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    repeat (2) @(posedge link_clk);
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge link_clk);
  endtask
  initial begin
    #300000;
    bad_count++;
    summarize();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 9; i++) begin
      cfg(rows[i].ctrl, rows[i].al, rows[i].write_column_latency);
      chk(crc_p, rows[i].crcp);
      apb(1'b0, sdwb_pkg::ADDR_STATUS, 32'h0);
      chk(rd[sdwb_pkg::ST_CRCP], rows[i].crcp);
      chk(rd[sdwb_pkg::ST_MASK], rows[i].ctrl[3] && !rows[i].ctrl[4]);
      chk(rd[sdwb_pkg::ST_CONFL], rows[i].ctrl[3] && rows[i].ctrl[4]);
      sdwb_ctrl_model_inst.issue(rows[i].a12, rows[i].a10, 4'(i), 10'(64 * i + 1), rows[i].mask, t0);
      repeat (rows[i].al + rows[i].write_column_latency + 8) @(posedge link_clk);
      chk_burst(t0, rows[i].al + rows[i].write_column_latency, rows[i].n, 4'(i), 10'(64 * i + 1), rows[i].be,
        rows[i].a10);
      chk(we_t.size(), 0);
    end
    // spacing four and five with one-clock preamble raise no flag
    cfg(8'h00, 6'h00, 6'h09);
    pair(4, 9);
    pair(5, 9);
    apb(1'b0, sdwb_pkg::ADDR_STATUS, 32'h0);
    chk(rd[sdwb_pkg::ST_SPACE], 0);
    // two-clock preamble: six apart is fine, five and latency nine are flagged
    cfg(8'h04, 6'h00, 6'h0A);
    pair(6, 10);
    apb(1'b0, sdwb_pkg::ADDR_STATUS, 32'h0);
    chk(rd[sdwb_pkg::ST_SPACE], 0);
    chk(rd[sdwb_pkg::ST_CWL], 0);
    pair(5, 10);
    apb(1'b0, sdwb_pkg::ADDR_STATUS, 32'h0);
    chk(rd[sdwb_pkg::ST_SPACE], 1);
    cfg(8'h04, 6'h00, 6'h09);
    sdwb_ctrl_model_inst.issue(1'b1, 1'b0, 4'h2, 10'h010, 4'hF, t0);
    repeat (19) @(posedge link_clk);
    chk_burst(t0, 9, 4, 4'h2, 10'h010, 4'hF, 1'b0);
    apb(1'b0, sdwb_pkg::ADDR_STATUS, 32'h0);
    chk(rd[sdwb_pkg::ST_CWL], 1);
    apb(1'b0, sdwb_pkg::ADDR_COUNT, 32'h0);
    chk(rd, bursts);
    // refused accesses
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1);
    chk(rd, 32'h0);
    apb(1'b1, sdwb_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    chk(er, 1);
    // second reset restores the reset config (column latency 9) and clears sticky flags
    do_reset();
    apb(1'b0, sdwb_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, sdwb_pkg::ADDR_LAT, 32'h0);
    chk(rd, 32'h00000900);
    apb(1'b0, sdwb_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
